//--- verilog/rsac_pkg.sv
// Purpose: Shared constants for the radio loop-table and gain-lock block.
// Assumes: 8-bit registers reached through a plain address/strobe port.
// Notes:   Reset values are all zero so the block starts on ROM tables.
`default_nettype none

package rsac_pkg;

    // Register port widths.
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;

    // Register offsets.
    localparam logic [9:0] OFS_RESERVED_A = 10'h111;
    localparam logic [9:0] OFS_PHASE_RXCFG = 10'h112;
    localparam logic [9:0] OFS_LOCK_TABLE = 10'h113;

    // Reset values.
    localparam logic [7:0] RST_RESERVED_A = 8'h00;
    localparam logic [7:0] RST_PHASE_RXCFG = 8'h00;
    localparam logic [7:0] RST_LOCK_TABLE = 8'h00;

    // Field positions in the phase and receive-loop register.
    localparam int unsigned RXA_MSB = 7;
    localparam int unsigned RXA_LSB = 2;
    localparam int unsigned PHASE_MSB = 1;
    localparam int unsigned PHASE_LSB = 0;

    // Field positions in the lock-mode and table-control register.
    localparam int unsigned LOCK_MSB = 7;
    localparam int unsigned LOCK_LSB = 6;
    localparam int unsigned SRC_MSB = 5;
    localparam int unsigned SRC_LSB = 4;
    localparam int unsigned RXB_MSB = 3;
    localparam int unsigned RXB_LSB = 0;

    // Gain-control lock modes.
    localparam logic [1:0] LOCK_FREE = 2'h0;
    localparam logic [1:0] LOCK_MANUAL = 2'h1;
    localparam logic [1:0] LOCK_HOLD = 2'h2;
    localparam logic [1:0] LOCK_AFTER_SYNC = 2'h3;

    // Loop-table sources.
    localparam logic [1:0] SRC_ROM_BOTH = 2'h0;
    localparam logic [1:0] SRC_RX_CUSTOM = 2'h1;
    localparam logic [1:0] SRC_TX_RAM = 2'h2;
    localparam logic [1:0] SRC_BOTH_CUSTOM = 2'h3;

    // Custom transmit table location in packet RAM.
    localparam logic [7:0] PRAM_TX_FIRST = 8'h10;
    localparam logic [7:0] PRAM_TX_LAST = 8'h18;
    localparam int unsigned TX_TABLE_DEPTH = 9;
    localparam logic [3:0] TX_TABLE_LAST_IDX = 4'h8;

    // Table fetch sequencer states.
    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_READ,
        FETCH_DRAIN
    } rsac_fetch_type;

endpackage

`default_nettype wire

//--- verilog/rsac_top.sv
// Purpose: Radio configuration registers that steer the correlator phase,
//          the gain-control lock and the PLL loop-table selection.
// Assumes: Tx/Rx/sleep entry pulses, detector pulses and packet RAM data
//          come from logic on i_clk; packet RAM answers one cycle after
//          a read request.
// Notes:   A transmit entry with a RAM source copies nine bytes of
//          packet RAM into a local table before it is reported valid.
//
// Functional notes
// - Sources 1 or 3 apply setting B to loop.
// - Phase field sets correlator demodulator phase.
// - Lock mode 3 locks on sync only unqualified.
// - Source 0 loads ROM tables each Tx/Rx entry.
// - ROM: narrow in receive, rate-based in transmit.
// - Source 1 builds receive table, ROM for transmit.
// - Source 2 takes transmit table from RAM 0x10-0x18.
// - Source 3 uses custom receive and RAM transmit.
`timescale 1ns/1ps
`default_nettype none

module rsac_top
    import rsac_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    // Register port.
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // Radio state entry pulses.
    input  wire logic              i_enter_tx,
    input  wire logic              i_enter_rx,
    input  wire logic              i_enter_sleep,
    // Gain-control detector inputs.
    input  wire logic              i_preamble_qual,
    input  wire logic              i_preamble_found,
    input  wire logic              i_sync_found,
    // Packet RAM read port.
    input  wire logic [7:0]        i_pram_data,
    output logic      [7:0]        o_pram_addr,
    output logic                   o_pram_rd,
    // Local transmit table lookup.
    input  wire logic [3:0]        i_lut_idx,
    output logic      [7:0]        o_lut_data,
    // Demodulator and gain control.
    output logic      [1:0]        o_correlator_phase,
    output logic      [1:0]        o_gain_mode,
    output logic                   o_gain_locked,
    output logic                   o_gain_freeze,
    // Loop-table selection.
    output logic                   o_lut_load,
    output logic                   o_lut_is_tx,
    output logic                   o_rx_custom,
    output logic      [9:0]        o_rx_loop_cfg,
    output logic                   o_rx_narrow,
    output logic                   o_tx_rate_based,
    output logic                   o_tx_from_ram,
    output logic                   o_tx_table_busy,
    output logic                   o_tx_table_valid
);

    // Receive side is custom for sources 1 and 3.
    function automatic logic src_rx_custom(input logic [1:0] src);
        return src[0];
    endfunction

    // Transmit side comes from packet RAM for sources 2 and 3.
    function automatic logic src_tx_ram(input logic [1:0] src);
        return src[1];
    endfunction

    logic                   rst_meta_r;
    logic                   rst_n_r;
    logic [7:0]             reserved_a_r;
    logic [7:0]             phase_rxcfg_r;
    logic [7:0]             lock_table_r;
    logic [1:0]             src;
    logic [5:0]             rx_set_a;
    logic [3:0]             rx_set_b;
    logic                   lock_set;
    logic                   locked_nxt;
    rsac_fetch_type         fetch_r;
    logic [3:0]             fetch_idx_r;
    logic                   cap_v_r;
    logic [3:0]             cap_idx_r;
    logic [7:0]             table_r [TX_TABLE_DEPTH];
    logic                   tx_start;

    // Reset release goes through two flops so every flop on rst_n_r leaves reset on
    // the same edge; assertion stays asynchronous.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Field views of the stored registers.
    assign src      = lock_table_r[SRC_MSB:SRC_LSB];
    assign rx_set_a = phase_rxcfg_r[RXA_MSB:RXA_LSB];
    assign rx_set_b = lock_table_r[RXB_MSB:RXB_LSB];

    // Register writes. The reserved byte is stored as written; the
    // hardware only returns it on readback, so a nonzero value has no other effect.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reserved_a_r  <= RST_RESERVED_A;
            phase_rxcfg_r <= RST_PHASE_RXCFG;
            lock_table_r  <= RST_LOCK_TABLE;
        end else if (i_wr) begin
            if (i_addr == OFS_RESERVED_A) begin
                reserved_a_r <= i_wdata;
            end
            if (i_addr == OFS_PHASE_RXCFG) begin
                phase_rxcfg_r <= i_wdata;
            end
            if (i_addr == OFS_LOCK_TABLE) begin
                lock_table_r <= i_wdata;
            end
        end
    end

    // Read data lands one cycle after the strobe; unmapped reads give 0.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_RESERVED_A:  o_rdata <= reserved_a_r;
                OFS_PHASE_RXCFG: o_rdata <= phase_rxcfg_r;
                OFS_LOCK_TABLE:  o_rdata <= lock_table_r;
                default:         o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Demodulator phase and lock mode follow the registers one cycle later.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_correlator_phase <= RST_PHASE_RXCFG[PHASE_MSB:PHASE_LSB];
            o_gain_mode        <= RST_LOCK_TABLE[LOCK_MSB:LOCK_LSB];
        end else begin
            o_correlator_phase <= phase_rxcfg_r[PHASE_MSB:PHASE_LSB];
            o_gain_mode        <= lock_table_r[LOCK_MSB:LOCK_LSB];
        end
    end

    // Lock after preamble, or after sync only when the preamble qualifier
    // is off. A lock event in the same cycle as a receive entry is kept.
    assign lock_set = (o_gain_mode == LOCK_AFTER_SYNC) &&
                      (i_preamble_found ||
                       (i_sync_found && !i_preamble_qual));
    always_comb begin
        locked_nxt = o_gain_locked;
        if (o_gain_mode != LOCK_AFTER_SYNC || i_enter_rx) begin
            locked_nxt = 1'b0;
        end
        if (lock_set) begin
            locked_nxt = 1'b1;
        end
    end

    // Gain is frozen in hold mode, or once locked in lock mode.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_gain_locked <= 1'b0;
            o_gain_freeze <= 1'b0;
        end else begin
            o_gain_locked <= locked_nxt;
            o_gain_freeze <= (o_gain_mode == LOCK_HOLD) ||
                             ((o_gain_mode == LOCK_AFTER_SYNC) &&
                              locked_nxt);
        end
    end

    // Table choice on each Tx/Rx entry; transmit wins if both arrive.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_lut_load      <= 1'b0;
            o_lut_is_tx     <= 1'b0;
            o_rx_custom     <= 1'b0;
            o_rx_loop_cfg   <= 10'h000;
            o_rx_narrow     <= 1'b0;
            o_tx_rate_based <= 1'b0;
            o_tx_from_ram   <= 1'b0;
        end else begin
            o_lut_load <= i_enter_tx || i_enter_rx;
            if (i_enter_tx) begin
                o_lut_is_tx     <= 1'b1;
                o_rx_custom     <= 1'b0;
                o_rx_narrow     <= 1'b0;
                o_tx_from_ram   <= src_tx_ram(src);
                o_tx_rate_based <= !src_tx_ram(src);
            end else if (i_enter_rx) begin
                o_lut_is_tx     <= 1'b0;
                o_tx_from_ram   <= 1'b0;
                o_tx_rate_based <= 1'b0;
                o_rx_custom     <= src_rx_custom(src);
                o_rx_narrow     <= !src_rx_custom(src);
                // Custom loop value is A and B side by side.
                o_rx_loop_cfg   <= src_rx_custom(src) ?
                                   {rx_set_a, rx_set_b} : 10'h000;
            end
        end
    end

    // A fetch only starts from idle; a transmit entry during a fetch
    // keeps the copy already under way rather than tearing it.
    assign tx_start = i_enter_tx && src_tx_ram(src) &&
                      (fetch_r == FETCH_IDLE);

    // Walk packet RAM from the first to the last table byte.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fetch_r          <= FETCH_IDLE;
            fetch_idx_r      <= 4'h0;
            o_pram_rd        <= 1'b0;
            o_pram_addr      <= 8'h00;
            o_tx_table_busy  <= 1'b0;
            o_tx_table_valid <= 1'b0;
        end else begin
            unique case (fetch_r)
                FETCH_IDLE: begin
                    if (tx_start) begin
                        fetch_r          <= FETCH_READ;
                        fetch_idx_r      <= 4'h0;
                        o_pram_rd        <= 1'b1;
                        o_pram_addr      <= PRAM_TX_FIRST;
                        o_tx_table_busy  <= 1'b1;
                        o_tx_table_valid <= 1'b0;
                    end
                end
                FETCH_READ: begin
                    if (fetch_idx_r == TX_TABLE_LAST_IDX) begin
                        fetch_r   <= FETCH_DRAIN;
                        o_pram_rd <= 1'b0;
                    end else begin
                        fetch_idx_r <= fetch_idx_r + 4'h1;
                        o_pram_addr <= o_pram_addr + 8'h01;
                    end
                end
                FETCH_DRAIN: begin
                    fetch_r          <= FETCH_IDLE;
                    o_tx_table_busy  <= 1'b0;
                    o_tx_table_valid <= 1'b1;
                end
            endcase
            // Packet RAM is lost in sleep, so the copy is stale.
            if (i_enter_sleep) begin
                o_tx_table_valid <= 1'b0;
            end
        end
    end

    // Capture RAM data one cycle after each read request.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cap_v_r   <= 1'b0;
            cap_idx_r <= 4'h0;
        end else begin
            cap_v_r   <= o_pram_rd;
            cap_idx_r <= fetch_idx_r;
        end
    end

    // Table storage; no reset, contents only count once valid.
    always_ff @(posedge i_clk) begin
        if (cap_v_r) begin
            table_r[cap_idx_r] <= i_pram_data;
        end
    end

    // Registered lookup; out-of-range indices read as zero.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_lut_data <= 8'h00;
        end else if (i_lut_idx <= TX_TABLE_LAST_IDX) begin
            o_lut_data <= table_r[i_lut_idx];
        end else begin
            o_lut_data <= 8'h00;
        end
    end

    // Checks on the behaviour above.
    property p_phase_follows;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_wr && i_addr == OFS_PHASE_RXCFG) |-> ##2
        o_correlator_phase == $past(i_wdata[1:0], 2);
    endproperty
    a_phase_follows: assert property (p_phase_follows)
        else $error("Correlator phase did not follow register write.");

    property p_mode_follows;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_wr && i_addr == OFS_LOCK_TABLE) |-> ##2
        o_gain_mode == $past(i_wdata[7:6], 2);
    endproperty
    a_mode_follows: assert property (p_mode_follows)
        else $error("Gain lock mode did not follow register write.");

    property p_sync_qualified;
        @(posedge i_clk) disable iff (!rst_n_r)
        (o_gain_mode == LOCK_AFTER_SYNC && i_sync_found && i_preamble_qual
         && !i_preamble_found && !o_gain_locked) |=> !o_gain_locked;
    endproperty
    a_sync_qualified: assert property (p_sync_qualified)
        else $error("Gain locked on sync word while qualifier set.");

    property p_rom_load;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_enter_rx && !i_enter_tx && src == SRC_ROM_BOTH) |=>
        o_lut_load && !o_rx_custom && !o_lut_is_tx;
    endproperty
    a_rom_load: assert property (p_rom_load)
        else $error("ROM table not loaded on receive entry.");

    property p_rom_bw;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_enter_tx && !src_tx_ram(src)) |=>
        o_tx_rate_based && !o_rx_narrow && !o_tx_from_ram;
    endproperty
    a_rom_bw: assert property (p_rom_bw)
        else $error("ROM transmit bandwidth not rate based.");

    property p_rx_custom;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_enter_rx && !i_enter_tx && src_rx_custom(src)) |=>
        o_rx_custom && o_rx_loop_cfg == {$past(rx_set_a), $past(rx_set_b)};
    endproperty
    a_rx_custom: assert property (p_rx_custom)
        else $error("Custom receive loop value not applied.");

    property p_rx_src1;
        @(posedge i_clk) disable iff (!rst_n_r)
        (i_enter_tx && src == SRC_RX_CUSTOM) |=> !o_tx_from_ram && !o_pram_rd;
    endproperty
    a_rx_src1: assert property (p_rx_src1)
        else $error("Source 1 wrongly fetched transmit table.");

    property p_ram_walk;
        @(posedge i_clk) disable iff (!rst_n_r)
        tx_start |=> o_pram_rd && o_pram_addr == PRAM_TX_FIRST ##8
        o_pram_rd && o_pram_addr == PRAM_TX_LAST ##1 !o_pram_rd;
    endproperty
    a_ram_walk: assert property (p_ram_walk)
        else $error("Packet RAM walk did not cover table range.");

    property p_both_custom;
        @(posedge i_clk) disable iff (!rst_n_r)
        (tx_start && src == SRC_BOTH_CUSTOM) |=>
        o_tx_from_ram && o_tx_table_busy ##10 !o_tx_table_busy;
    endproperty
    a_both_custom: assert property (p_both_custom)
        else $error("Source 3 transmit fetch did not complete.");

    c_rx_custom: cover property (@(posedge i_clk) disable iff (!rst_n_r)
        i_enter_rx && src == SRC_BOTH_CUSTOM);
    c_table_ready: cover property (@(posedge i_clk) disable iff (!rst_n_r)
        $rose(o_tx_table_valid));
    c_sync_lock: cover property (@(posedge i_clk) disable iff (!rst_n_r)
        $rose(o_gain_locked) && !$past(i_preamble_found));

endmodule

`default_nettype wire

//--- verification/rsac_top_tb.sv
// Purpose: Self-checking bench for the radio loop-table register block.
// Assumes: Packet RAM is modelled here with a one-cycle registered answer.
// Notes:   Plain register cases run from a table; the rest by hand.
`timescale 1ns/1ps
`default_nettype none

module rsac_top_tb;
    import rsac_pkg::*;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] phase;
        logic [1:0] mode;
    } rsac_row_type;

    logic              i_clk, i_arst_n, i_wr, i_rd;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic              i_enter_tx, i_enter_rx, i_enter_sleep;
    logic              i_preamble_qual, i_preamble_found, i_sync_found;
    logic [7:0]        i_pram_data, o_pram_addr, o_lut_data;
    logic              o_pram_rd, o_gain_locked, o_gain_freeze, o_lut_load;
    logic [3:0]        i_lut_idx;
    logic [1:0]        o_correlator_phase, o_gain_mode;
    logic              o_lut_is_tx, o_rx_custom, o_rx_narrow;
    logic [9:0]        o_rx_loop_cfg;
    logic              o_tx_rate_based, o_tx_from_ram;
    logic              o_tx_table_busy, o_tx_table_valid;
    int                err_total, n_checks;
    rsac_row_type      rows [8];

    rsac_top dut_u (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_enter_tx(i_enter_tx), .i_enter_rx(i_enter_rx),
        .i_enter_sleep(i_enter_sleep), .i_preamble_qual(i_preamble_qual),
        .i_preamble_found(i_preamble_found), .i_sync_found(i_sync_found),
        .i_pram_data(i_pram_data), .o_pram_addr(o_pram_addr),
        .o_pram_rd(o_pram_rd), .i_lut_idx(i_lut_idx),
        .o_lut_data(o_lut_data), .o_correlator_phase(o_correlator_phase),
        .o_gain_mode(o_gain_mode), .o_gain_locked(o_gain_locked),
        .o_gain_freeze(o_gain_freeze), .o_lut_load(o_lut_load),
        .o_lut_is_tx(o_lut_is_tx), .o_rx_custom(o_rx_custom),
        .o_rx_loop_cfg(o_rx_loop_cfg), .o_rx_narrow(o_rx_narrow),
        .o_tx_rate_based(o_tx_rate_based), .o_tx_from_ram(o_tx_from_ram),
        .o_tx_table_busy(o_tx_table_busy),
        .o_tx_table_valid(o_tx_table_valid)
    );

    // Free-running 200 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Packet RAM answers one cycle after a read; when idle the bus toggles
    // so that a late sample can never match by luck.
    always @(posedge i_clk) begin
        if (o_pram_rd) begin
            i_pram_data <= o_pram_addr ^ 8'h5a;
        end else begin
            i_pram_data <= ~i_pram_data;
        end
    end

    // Compares any result, widened to ten bits, with case equality.
    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // One-cycle register read; data are looked at in the next cycle only.
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", {2'h0, e}, {2'h0, o_rdata});
    endtask

    // One-cycle event pulse: {tx, rx, sleep, preamble, sync}.
    task automatic ev(input logic [4:0] m);
        @(posedge i_clk);
        {i_enter_tx, i_enter_rx, i_enter_sleep, i_preamble_found,
         i_sync_found} <= m;
        @(posedge i_clk);
        {i_enter_tx, i_enter_rx, i_enter_sleep, i_preamble_found,
         i_sync_found} <= 5'h00;
        #1;
    endtask

    // Single place where the run ends.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        #20000;
        err_total++;
        $display("MISMATCH watchdog expected done seen hang");
        finish_test();
    end

    // Main sequence.
    initial begin
        logic [1:0] src;
        logic [7:0] ta;
        {i_arst_n, i_wr, i_rd, i_addr, i_wdata, i_lut_idx} = '0;
        {i_enter_tx, i_enter_rx, i_enter_sleep} = 3'h0;
        {i_preamble_qual, i_preamble_found, i_sync_found} = 3'h0;
        i_pram_data = 8'h00;
        err_total = 0;
        n_checks = 0;
        rows[0] = '{10'h112, 8'h03, 8'h03, 2'h3, 2'h0};
        rows[1] = '{10'h112, 8'h02, 8'h02, 2'h2, 2'h0};
        rows[2] = '{10'h113, 8'h40, 8'h40, 2'h2, 2'h1};
        rows[3] = '{10'h113, 8'h80, 8'h80, 2'h2, 2'h2};
        rows[4] = '{10'h113, 8'hc0, 8'hc0, 2'h2, 2'h3};
        rows[5] = '{10'h113, 8'h00, 8'h00, 2'h2, 2'h0};
        rows[6] = '{10'h111, 8'h00, 8'h00, 2'h2, 2'h0};
        rows[7] = '{10'h3ff, 8'hff, 8'h00, 2'h2, 2'h0};
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd_chk(OFS_RESERVED_A, RST_RESERVED_A);
        rd_chk(OFS_PHASE_RXCFG, RST_PHASE_RXCFG);
        rd_chk(OFS_LOCK_TABLE, RST_LOCK_TABLE);
        $display("test reset done");
        // Table rows: the reserved register is only ever written zero.
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            @(posedge i_clk);
            #1;
            chk("phase", 10'(rows[i].phase),
                10'(o_correlator_phase));
            chk("mode", {8'h0, rows[i].mode}, {8'h0, o_gain_mode});
            rd_chk(rows[i].addr, rows[i].rdata);
        end
        $display("test registers done");
        // Every table source, receive then transmit entry.
        for (int s = 0; s < 4; s++) begin
            src = s[1:0];
            wr(OFS_PHASE_RXCFG, src[0] ? 8'hb5 : 8'h01);
            wr(OFS_LOCK_TABLE, {2'h0, src, 4'h9});
            ev(5'b01000);
            chk("load", 10'h1, {9'h0, o_lut_load});
            chk("is_tx", 10'h0, {9'h0, o_lut_is_tx});
            chk("rx_custom", {9'h0, src[0]}, {9'h0, o_rx_custom});
            chk("rx_narrow", {9'h0, ~src[0]}, {9'h0, o_rx_narrow});
            chk("rx_cfg", src[0] ? 10'h2d9 : 10'h0, o_rx_loop_cfg);
            @(posedge i_clk);
            #1;
            chk("load", 10'h0, {9'h0, o_lut_load});
            ev(5'b10000);
            chk("is_tx", 10'h1, {9'h0, o_lut_is_tx});
            chk("tx_rate", {9'h0, ~src[1]}, {9'h0, o_tx_rate_based});
            chk("tx_ram", {9'h0, src[1]}, {9'h0, o_tx_from_ram});
            if (src[1]) begin
                // Source 3 retriggers transmit mid-fetch; no restart.
                for (int k = 0; k < 9; k++) begin
                    ta = PRAM_TX_FIRST + 8'(k);
                    chk("pram_rd", 10'h1, {9'h0, o_pram_rd});
                    chk("pram_addr", {2'h0, ta}, 10'(o_pram_addr));
                    chk("busy", 10'h1, {9'h0, o_tx_table_busy});
                    @(posedge i_clk);
                    i_enter_tx <= (s == 3 && k == 4);
                    #1;
                end
                chk("pram_rd", 10'h0, {9'h0, o_pram_rd});
                @(posedge i_clk);
                #1;
                chk("busy", 10'h0, {9'h0, o_tx_table_busy});
                chk("valid", 10'h1, {9'h0, o_tx_table_valid});
                for (int k = 0; k < 10; k++) begin
                    @(posedge i_clk);
                    i_lut_idx <= 4'(k);
                    @(posedge i_clk);
                    #1;
                    ta = (k < 9) ? ((PRAM_TX_FIRST + 8'(k)) ^ 8'h5a) : 8'h00;
                    chk("lut", {2'h0, ta}, {2'h0, o_lut_data});
                end
                // The RAM model keeps its table, standing in for a reload.
                ev(5'b00100);
                chk("valid", 10'h0, {9'h0, o_tx_table_valid});
            end
        end
        $display("test sources done");
        // Gain lock: sync ignored when qualified, preamble always locks.
        wr(OFS_LOCK_TABLE, 8'hc0);
        @(posedge i_clk);
        i_preamble_qual <= 1'b1;
        ev(5'b00001);
        chk("locked", 10'h0, {9'h0, o_gain_locked});
        @(posedge i_clk);
        i_preamble_qual <= 1'b0;
        ev(5'b00001);
        chk("locked", 10'h1, {9'h0, o_gain_locked});
        chk("freeze", 10'h1, {9'h0, o_gain_freeze});
        wr(OFS_LOCK_TABLE, 8'h80);
        repeat (2) @(posedge i_clk);
        #1;
        chk("locked", 10'h0, {9'h0, o_gain_locked});
        chk("freeze", 10'h1, {9'h0, o_gain_freeze});
        wr(OFS_LOCK_TABLE, 8'hc0);
        @(posedge i_clk);
        i_preamble_qual <= 1'b1;
        ev(5'b00010);
        chk("locked", 10'h1, {9'h0, o_gain_locked});
        ev(5'b01000);
        chk("locked", 10'h0, {9'h0, o_gain_locked});
        $display("test gain lock done");
        // Reset in mid-run clears fields at once and on readback.
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        #1;
        chk("phase", 10'h0, {8'h0, o_correlator_phase});
        chk("mode", 10'h0, {8'h0, o_gain_mode});
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd_chk(OFS_PHASE_RXCFG, RST_PHASE_RXCFG);
        $display("test second reset done");
        finish_test();
    end
endmodule

`default_nettype wire
